// [dtpi_cfg.svh]
// Constants of the dancer / tension PI loop: register offsets, field
// positions, reset values and timing counts.
// Assumes it is included by its bare name and that 32-bit APB words are used.
//
// Overview of operation
// [R1] Type field picks voltage or current feedback.
// [R2] Proportional gain 0 to 9999 scales error.
// [R3] Integration time zero disables integral term.
// [R4] Tolerance window suppresses correction near target.
// [R5] Target equals signed offset percentage setting.
// [R6] Alarm when feedback leaves symmetric band.
// [R7] Correction magnitude clamped to maximum millivolts.
// [R8] Settings act only in modes 1, 2.
// [R9] Mode sets correction direction versus feedback.
// [R10] Tension mode disables encoder differential counter.
// [R11] Recompute per sample; integrator zero when off.
`ifndef DTPI_CFG_SVH
`define DTPI_CFG_SVH

// ****************************************************************
// Register byte offsets.
// ****************************************************************
`define DTPI_OFS_CTRL 8'h00
`define DTPI_OFS_PGAIN 8'h04
`define DTPI_OFS_ITIME 8'h08
`define DTPI_OFS_WINDOW 8'h0C
`define DTPI_OFS_OFFSET 8'h10
`define DTPI_OFS_ALARM 8'h14
`define DTPI_OFS_MAXCORR 8'h18
`define DTPI_OFS_STATUS 8'h1C
`define DTPI_OFS_FEEDBACK 8'h20
`define DTPI_OFS_CORR 8'h24
`define DTPI_OFS_INT_STAT 8'h28
`define DTPI_OFS_INT_CLR 8'h2C
`define DTPI_OFS_INT_EN 8'h30

// ****************************************************************
// Field positions and setting limits.
// ****************************************************************
`define DTPI_CTRL_TYPE_LSB 8
`define DTPI_MODE_UP 2'h1
`define DTPI_MODE_DOWN 2'h2
`define DTPI_TYPE_VOLT 2'h1
`define DTPI_TYPE_CURR 2'h2
`define DTPI_GAIN_MAX 14'h270F
`define DTPI_MV_MAX 14'h270F
`define DTPI_PCT_MAX 10'h3E8
`define DTPI_PCT_FULL 1000
`define DTPI_FB_FULL 32767
`define DTPI_GAIN_SHIFT 10

// ****************************************************************
// Reset values.
// ****************************************************************
`define DTPI_RST_MODE 2'h0
`define DTPI_RST_TYPE 2'h1
`define DTPI_RST_GAIN 14'h03E8
`define DTPI_RST_ITIME 14'h0000
`define DTPI_RST_WINDOW 10'h000
`define DTPI_RST_OFFSET 12'h000
`define DTPI_RST_ALARM 10'h3E8
`define DTPI_RST_MAXCORR 14'h270F

// ****************************************************************
// Timing: integrator time base of one millisecond.
// ****************************************************************
`define DTPI_CLK_HZ 25000000
`define DTPI_TICK_MS 1
`define DTPI_MS_CYCLES ((`DTPI_CLK_HZ / 1000) * `DTPI_TICK_MS)

`endif

// [dtpi_pkg.sv]
// Types shared by the dancer / tension PI loop modules.
// Assumes the constants header supplies all numeric values.
`default_nettype none
package dtpi_pkg;

    // Pipeline phase of one control cycle.
    typedef enum logic [1:0] {
        PH_WAIT,
        PH_ERR,
        PH_OUT
    } dtpi_phase_type;

    // Whole state of the top module.
    typedef struct packed {
        dtpi_phase_type phase;
        logic [1:0] mode;
        logic [1:0] fbsel;
        logic [13:0] kp;
        logic [13:0] ti;
        logic [13:0] maxc;
        logic [9:0] win;
        logic [9:0] alm;
        logic signed [11:0] ofs;
        logic [1:0] ist;
        logic [1:0] ien;
        logic signed [15:0] fb;
        logic signed [16:0] err;
        logic signed [15:0] acc;
        logic signed [15:0] corr;
        logic alarm;
        logic clamp;
        logic cval;
        logic [15:0] mscnt;
        logic [13:0] icnt;
        logic idue;
        logic [31:0] rdata;
        logic slverr;
    } dtpi_state_type;

endpackage : dtpi_pkg
`default_nettype wire

// [dtpi_scale_if.sv]
// Carrier between the loop core and its percent-to-count scalers.
// Assumes percentages in tenths of a percent, signed.
`timescale 1ns/10ps
`default_nettype none
interface dtpi_scale_if;
    logic signed [11:0] pct; // Setting in tenths of a percent.
    logic signed [16:0] cnt; // Same value in feedback counts.
    modport user (output pct, input cnt);
    modport scaler (input pct, output cnt);
endinterface : dtpi_scale_if
`default_nettype wire

// [dtpi_pct_scale.sv]
// Converts a percentage of feedback full scale into feedback counts.
// Assumes the feedback word is signed with full scale at the positive limit.
`include "dtpi_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module dtpi_pct_scale (
    dtpi_scale_if.scaler sc // Percent in, counts out.
);
    // ****************************************************************
    // Scaling.
    // ****************************************************************
    logic signed [31:0] prod; // Percent times full scale.

    // Division by a constant; synthesis turns it into a multiplier.
    always_comb begin
        prod = 32'(sc.pct) * 32'(`DTPI_FB_FULL);
        sc.cnt = 17'(prod / 32'(`DTPI_PCT_FULL));
    end
endmodule : dtpi_pct_scale
`default_nettype wire

// [dtpi_sat.sv]
// Saturates a signed value to a symmetric millivolt limit.
// Assumes the limit never exceeds the 16-bit signed range.
`timescale 1ns/10ps
`default_nettype none
module dtpi_sat #(
    parameter int IW = 22 // Width of the value to clamp.
) (
    input wire logic signed [IW-1:0] val_i, // Value to clamp.
    input wire logic [13:0] lim_i, // Magnitude limit.
    output logic signed [15:0] val_o, // Clamped value.
    output logic hit_o // High when clamping acted.
);
    // ****************************************************************
    // Clamp.
    // ****************************************************************
    logic signed [IW-1:0] lim; // Limit widened to the value.

    // Compare against both signs of the limit.
    always_comb begin
        lim = IW'(signed'({1'b0, lim_i}));
        hit_o = 1'b1;
        if (val_i > lim) begin
            val_o = 16'(lim);
        end else if (val_i < -lim) begin
            val_o = 16'(-lim);
        end else begin
            val_o = 16'(val_i);
            hit_o = 1'b0;
        end
    end
endmodule : dtpi_sat
`default_nettype wire

// [dtpi_tension_pi.sv]
// Dancer / tension PI loop with APB registers and one interrupt.
// Assumes the feedback words come from converter logic on ref_clk_i,
// qualified by fb_valid_i; no synchronisers are needed for them.
`include "dtpi_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module dtpi_tension_pi #(
    parameter int MS_CYCLES = `DTPI_MS_CYCLES // Clock cycles per millisecond.
) (
    input wire logic ref_clk_i, // Clock, 25 MHz.
    input wire logic resetn_i, // Synchronous reset, active low.
    input wire logic psel_i, // APB select.
    input wire logic penable_i, // APB enable.
    input wire logic pwrite_i, // APB direction.
    input wire logic [7:0] paddr_i, // APB byte address.
    input wire logic [31:0] pwdata_i, // APB write data.
    output logic [31:0] prdata_o, // APB read data.
    output logic pready_o, // APB ready.
    output logic pslverr_o, // APB error.
    input wire logic signed [15:0] fb_volt_i, // Voltage feedback sample.
    input wire logic signed [15:0] fb_curr_i, // Current feedback sample.
    input wire logic fb_valid_i, // New sample strobe.
    output logic signed [15:0] corr_o, // Correction in millivolts.
    output logic corr_valid_o, // Correction updated strobe.
    output logic alarm_o, // Tension alarm level.
    output logic pos_cnt_en_o, // Encoder differential counter enable.
    output logic irq_o // Interrupt level.
);
    // ****************************************************************
    // Declarations.
    // ****************************************************************
    dtpi_pkg::dtpi_state_type s_reg; // Registered state.
    dtpi_pkg::dtpi_state_type s_next; // Next state.
    dtpi_scale_if win_if (); // Window scaler carrier.
    dtpi_scale_if ofs_if (); // Offset scaler carrier.
    dtpi_scale_if alm_if (); // Alarm scaler carrier.
    logic active; // Loop is in a tension mode.
    logic wr_acc; // APB write access phase.
    logic rd_setup; // APB read setup phase.
    logic tick; // One millisecond elapsed.
    logic signed [16:0] fb_sel; // Selected feedback, widened.
    logic signed [16:0] dev; // Raw deviation from target.
    logic signed [16:0] dev_mag; // Magnitude of the deviation.
    logic signed [30:0] prod; // Gain times error.
    logic signed [21:0] pterm; // Scaled proportional term.
    logic signed [21:0] isum; // Integrator plus increment.
    logic signed [21:0] tot; // Proportional plus integral.
    logic signed [15:0] acc_sat; // Clamped integrator.
    logic signed [15:0] out_sat; // Clamped correction.
    logic out_hit; // Correction hit the limit.
    logic [1:0] ev; // Events of this cycle.
    logic [31:0] rd_mux; // Read data selection.
    logic [13:0] wv; // Write data, low bits.

    // ****************************************************************
    // Scalers and clamps.
    // ****************************************************************
    assign win_if.pct = 12'(signed'({1'b0, s_reg.win}));
    assign ofs_if.pct = s_reg.ofs;
    assign alm_if.pct = 12'(signed'({1'b0, s_reg.alm}));

    dtpi_pct_scale u_win (
        .sc (win_if)
    );

    dtpi_pct_scale u_ofs (
        .sc (ofs_if)
    );

    dtpi_pct_scale u_alm (
        .sc (alm_if)
    );

    // Integrator is held inside the limit so it cannot wind up.
    dtpi_sat #(.IW(22)) u_acc_sat (
        .val_i (isum),
        .lim_i (s_reg.maxc),
        .val_o (acc_sat),
        .hit_o ()
    );

    dtpi_sat #(.IW(22)) u_out_sat (
        .val_i (tot),
        .lim_i (s_reg.maxc),
        .val_o (out_sat),
        .hit_o (out_hit)
    );

    // ****************************************************************
    // Outputs.
    // ****************************************************************
    assign pready_o = 1'b1;
    assign prdata_o = s_reg.rdata;
    assign pslverr_o = s_reg.slverr & psel_i & penable_i;
    assign corr_o = s_reg.corr;
    assign corr_valid_o = s_reg.cval;
    assign alarm_o = s_reg.alarm;
    assign irq_o = |(s_reg.ist & s_reg.ien);
    // The encoder counter only runs while the loop is off.
    assign pos_cnt_en_o = ~active; // [R10]

    // ****************************************************************
    // Decoding helpers.
    // ****************************************************************

    // Only modes 1 and 2 enable the loop and its settings.
    always_comb begin
        active = (s_reg.mode == `DTPI_MODE_UP) || (s_reg.mode == `DTPI_MODE_DOWN); // [R8]
        wr_acc = psel_i & penable_i & pwrite_i;
        rd_setup = psel_i & ~penable_i & ~pwrite_i;
        tick = (s_reg.mscnt == 16'(MS_CYCLES - 1));
        wv = pwdata_i[13:0];
    end

    // Source select and arithmetic of the control cycle.
    always_comb begin
        if (s_reg.fbsel == `DTPI_TYPE_CURR) begin
            fb_sel = 17'(fb_curr_i); // [R1]
        end else begin
            fb_sel = 17'(fb_volt_i); // [R1]
        end
        // Mode 1 speeds up on rising feedback, mode 2 on falling.
        if (s_reg.mode == `DTPI_MODE_UP) begin
            dev = 17'(s_reg.fb) - ofs_if.cnt; // [R5] [R9]
        end else begin
            dev = ofs_if.cnt - 17'(s_reg.fb); // [R5] [R9]
        end
        dev_mag = dev[16] ? -dev : dev;
        prod = 31'(signed'({1'b0, s_reg.kp})) * 31'(s_reg.err); // [R2]
        pterm = 22'(prod >>> `DTPI_GAIN_SHIFT);
        isum = 22'(s_reg.acc) + pterm;
        tot = pterm + 22'(s_reg.acc);
    end

    // Read multiplexer; unmapped addresses answer zero with an error.
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (paddr_i)
            `DTPI_OFS_CTRL: rd_mux = {22'h0, s_reg.fbsel, 6'h0, s_reg.mode};
            `DTPI_OFS_PGAIN: rd_mux = {18'h0, s_reg.kp};
            `DTPI_OFS_ITIME: rd_mux = {18'h0, s_reg.ti};
            `DTPI_OFS_WINDOW: rd_mux = {22'h0, s_reg.win};
            `DTPI_OFS_OFFSET: rd_mux = 32'(s_reg.ofs);
            `DTPI_OFS_ALARM: rd_mux = {22'h0, s_reg.alm};
            `DTPI_OFS_MAXCORR: rd_mux = {18'h0, s_reg.maxc};
            `DTPI_OFS_STATUS: rd_mux = {28'h0, ~active, active, s_reg.clamp, s_reg.alarm};
            `DTPI_OFS_FEEDBACK: rd_mux = 32'(s_reg.fb);
            `DTPI_OFS_CORR: rd_mux = 32'(s_reg.corr);
            `DTPI_OFS_INT_STAT: rd_mux = {30'h0, s_reg.ist};
            `DTPI_OFS_INT_EN: rd_mux = {30'h0, s_reg.ien};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // ****************************************************************
    // Next state.
    // ****************************************************************

    // Register writes, the control pipeline and the interrupt flags.
    always_comb begin
        s_next = s_reg;
        s_next.cval = 1'b0;
        ev = 2'h0;

        // Read data is latched in the setup cycle so it is a flop output.
        if (rd_setup) begin
            s_next.rdata = rd_mux;
            s_next.slverr = 1'b0;
        end
        if (psel_i & ~penable_i) begin
            s_next.slverr = 1'b1;
            case (paddr_i)
                `DTPI_OFS_CTRL, `DTPI_OFS_PGAIN, `DTPI_OFS_ITIME,
                `DTPI_OFS_WINDOW, `DTPI_OFS_OFFSET, `DTPI_OFS_ALARM,
                `DTPI_OFS_MAXCORR, `DTPI_OFS_STATUS, `DTPI_OFS_FEEDBACK,
                `DTPI_OFS_CORR, `DTPI_OFS_INT_STAT, `DTPI_OFS_INT_CLR,
                `DTPI_OFS_INT_EN: s_next.slverr = 1'b0;
                default: s_next.slverr = 1'b1;
            endcase
        end

        // Writes take effect in the access cycle; gain, window, offset, alarm and limit values saturate.
        if (wr_acc) begin
            case (paddr_i)
                `DTPI_OFS_CTRL: begin
                    s_next.mode = pwdata_i[1:0];
                    s_next.fbsel = pwdata_i[`DTPI_CTRL_TYPE_LSB +: 2];
                end
                `DTPI_OFS_PGAIN: begin
                    s_next.kp = (wv > `DTPI_GAIN_MAX) ? `DTPI_GAIN_MAX : wv; // [R2]
                end
                `DTPI_OFS_ITIME: s_next.ti = wv;
                `DTPI_OFS_WINDOW: begin
                    s_next.win = (wv > 14'(`DTPI_PCT_MAX)) ? `DTPI_PCT_MAX : wv[9:0];
                end
                `DTPI_OFS_OFFSET: begin
                    // Offset is signed tenths, limited to plus or minus full.
                    if ($signed(pwdata_i[11:0]) > $signed({2'h0, `DTPI_PCT_MAX})) begin
                        s_next.ofs = {2'h0, `DTPI_PCT_MAX};
                    end else if ($signed(pwdata_i[11:0]) < -$signed({2'h0, `DTPI_PCT_MAX})) begin
                        s_next.ofs = -$signed({2'h0, `DTPI_PCT_MAX});
                    end else begin
                        s_next.ofs = pwdata_i[11:0];
                    end
                end
                `DTPI_OFS_ALARM: begin
                    s_next.alm = (wv > 14'(`DTPI_PCT_MAX)) ? `DTPI_PCT_MAX : wv[9:0];
                end
                `DTPI_OFS_MAXCORR: begin
                    s_next.maxc = (wv > `DTPI_MV_MAX) ? `DTPI_MV_MAX : wv; // [R7]
                end
                `DTPI_OFS_INT_CLR: s_next.ist = s_reg.ist & ~pwdata_i[1:0];
                `DTPI_OFS_INT_EN: s_next.ien = pwdata_i[1:0];
                default: s_next.ist = s_reg.ist;
            endcase
        end

        // Free-running millisecond base for the integrator.
        s_next.mscnt = tick ? 16'h0000 : s_reg.mscnt + 16'h0001;
        if (tick && s_reg.ti != 14'h0000) begin
            // One integrator step falls due every ti milliseconds.
            if (s_reg.icnt >= s_reg.ti - 14'h0001) begin
                s_next.icnt = 14'h0000;
                s_next.idue = 1'b1; // [R3]
            end else begin
                s_next.icnt = s_reg.icnt + 14'h0001;
            end
        end

        // Control pipeline: capture, error, output.
        case (s_reg.phase)
            dtpi_pkg::PH_WAIT: begin
                if (fb_valid_i && active) begin
                    s_next.fb = 16'(fb_sel);
                    // Alarm band is symmetric about zero feedback.
                    s_next.alarm = (fb_sel > alm_if.cnt) || (fb_sel < -alm_if.cnt); // [R6]
                    ev[0] = s_next.alarm & ~s_reg.alarm;
                    s_next.phase = dtpi_pkg::PH_ERR;
                end
            end
            dtpi_pkg::PH_ERR: begin
                // Inside the window there is no proportional response.
                s_next.err = (dev_mag <= win_if.cnt) ? 17'h00000 : dev; // [R4]
                s_next.phase = dtpi_pkg::PH_OUT;
            end
            dtpi_pkg::PH_OUT: begin
                // The step that falls due is taken once, here.
                if (s_reg.idue && s_reg.ti != 14'h0000) begin
                    s_next.acc = acc_sat; // [R3] [R11]
                end
                if (s_reg.idue && !(tick && s_reg.ti != 14'h0000 && s_next.icnt == 14'h0000)) begin
                    s_next.idue = 1'b0;
                end
                s_next.corr = out_sat; // [R7] [R11]
                s_next.clamp = out_hit;
                ev[1] = out_hit & ~s_reg.clamp;
                s_next.cval = 1'b1;
                s_next.phase = dtpi_pkg::PH_WAIT;
            end
            default: s_next.phase = dtpi_pkg::PH_WAIT;
        endcase

        // With integration off no stale step may stay pending.
        if (s_reg.ti == 14'h0000) begin
            s_next.idue = 1'b0; // [R3]
            s_next.icnt = 14'h0000;
            s_next.acc = 16'h0000;
        end

        // Outside the tension modes the loop is parked and zeroed.
        if (!active) begin
            s_next.phase = dtpi_pkg::PH_WAIT; // [R8]
            s_next.acc = 16'h0000; // [R11]
            s_next.corr = 16'h0000;
            s_next.err = 17'h00000;
            s_next.alarm = 1'b0;
            s_next.clamp = 1'b0;
            s_next.idue = 1'b0;
            s_next.icnt = 14'h0000;
        end

        // A new event wins over a clear in the same cycle.
        s_next.ist = s_next.ist | ev;
    end

    // ****************************************************************
    // State register.
    // ****************************************************************

    // Synchronous reset loads the documented defaults.
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            s_reg <= '0;
            s_reg.phase <= dtpi_pkg::PH_WAIT;
            s_reg.mode <= `DTPI_RST_MODE;
            s_reg.fbsel <= `DTPI_RST_TYPE;
            s_reg.kp <= `DTPI_RST_GAIN;
            s_reg.ti <= `DTPI_RST_ITIME;
            s_reg.win <= `DTPI_RST_WINDOW;
            s_reg.ofs <= `DTPI_RST_OFFSET;
            s_reg.alm <= `DTPI_RST_ALARM;
            s_reg.maxc <= `DTPI_RST_MAXCORR;
        end else begin
            s_reg <= s_next;
        end
    end
endmodule : dtpi_tension_pi
`default_nettype wire

// [dtpi_tension_pi_asserts.sv]
// Port checker for the tension loop top module.
// Assumes one clock domain and the zero-wait APB of the top.
`timescale 1ns/10ps
`default_nettype none
module dtpi_asserts #(
    parameter int MS_CYCLES = 25000 // Cycles per millisecond.
) (
    input wire logic ref_clk_i, // Clock.
    input wire logic resetn_i, // Reset, active low.
    input wire logic psel_i, // APB select.
    input wire logic penable_i, // APB enable.
    input wire logic pwrite_i, // APB direction.
    input wire logic [7:0] paddr_i, // APB address.
    input wire logic [31:0] pwdata_i, // APB write data.
    input wire logic [31:0] prdata_o, // APB read data.
    input wire logic pready_o, // APB ready.
    input wire logic pslverr_o, // APB error.
    input wire logic signed [15:0] fb_volt_i, // Voltage sample.
    input wire logic signed [15:0] fb_curr_i, // Current sample.
    input wire logic fb_valid_i, // Sample strobe.
    input wire logic signed [15:0] corr_o, // Correction.
    input wire logic corr_valid_o, // Correction strobe.
    input wire logic alarm_o, // Alarm level.
    input wire logic pos_cnt_en_o, // Counter enable.
    input wire logic irq_o // Interrupt.
);
    // Everything here lives in the one loop clock domain.
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!resetn_i);
    a_ready_access: assert property (psel_i && penable_i |-> pready_o) else $error("ready low in access");
    a_unmapped_err: assert property (psel_i && penable_i && paddr_i > 8'h30 |-> pslverr_o)
        else $error("no error on unmapped address");
    a_mapped_ok: assert property (psel_i && penable_i && paddr_i <= 8'h30 && paddr_i[1:0] == 2'h0 |-> !pslverr_o)
        else $error("error on mapped address");
    a_answer_delay: assert property (corr_valid_o |-> $past(fb_valid_i, 3)) else $error("late strobe");
    a_valid_pulse: assert property (corr_valid_o |=> !corr_valid_o [*2]) else $error("strobe too long");
    a_corr_clamp: assert property (corr_o <= 16'sh270F && corr_o >= -16'sh270F) else $error("unclamped");
    a_idle_quiet: assert property (pos_cnt_en_o [*4] |-> corr_o == 16'h0000 && !alarm_o && !corr_valid_o)
        else $error("loop acts while off");
    a_corr_hold: assert property (!corr_valid_o && !pos_cnt_en_o && $past(!pos_cnt_en_o) |-> $stable(corr_o))
        else $error("correction moved without strobe");
    a_alarm_cause: assert property ($changed(alarm_o) |-> $past(fb_valid_i) || pos_cnt_en_o)
        else $error("alarm moved without sample");
    // Main scenarios reached by the bench.
    cover property (corr_valid_o && corr_o == -16'sh03E8);
    cover property (alarm_o && irq_o);
    cover property (pslverr_o);
endmodule : dtpi_asserts
bind dtpi_tension_pi dtpi_asserts #(.MS_CYCLES(MS_CYCLES)) u_chk (.ref_clk_i, .resetn_i, .psel_i, .penable_i,
    .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .fb_volt_i, .fb_curr_i, .fb_valid_i,
    .corr_o, .corr_valid_o, .alarm_o, .pos_cnt_en_o, .irq_o);
`default_nettype wire

// [dtpi_fb_model.sv]
// Model of the analogue feedback converter feeding the loop.
// Assumes words are only meaningful in the strobe cycle.
`timescale 1ns/10ps
`default_nettype none
module dtpi_fb_model (
    input wire logic clk_i, // Loop clock.
    output logic signed [15:0] volt_o, // Voltage word.
    output logic signed [15:0] curr_o, // Current word.
    output logic valid_o // Sample strobe.
);
    // Idle words are junk so a late capture shows up.
    initial begin
        volt_o = 16'h5A5A;
        curr_o = 16'hA5A5;
        valid_o = 1'b0;
    end
    // One sample: words with a one-cycle strobe, then inverted words.
    task automatic send(input logic signed [15:0] v, input logic signed [15:0] c);
        @(posedge clk_i);
        volt_o <= v;
        curr_o <= c;
        valid_o <= 1'b1;
        @(posedge clk_i);
        volt_o <= ~v;
        curr_o <= ~c;
        valid_o <= 1'b0;
    endtask : send
endmodule : dtpi_fb_model
`default_nettype wire

// [test_dancer_tension_pi_control.sv]
// Self-checking bench for the tension loop top module.
// Assumes the feedback model and the bound port checker.
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_count++; \
    $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module test_dancer_tension_pi_control;
    logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, fbval, cval, alarm, pce, irq, e, got;
    logic signed [15:0] fbv, fbc, corr;
    int err_count = 0, checked = 0;
    // A short millisecond keeps integrator steps quick.
    dtpi_tension_pi #(.MS_CYCLES(20)) dut (.ref_clk_i(clk), .resetn_i(rstn), .psel_i(psel), .penable_i(pen),
        .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .fb_volt_i(fbv), .fb_curr_i(fbc), .fb_valid_i(fbval), .corr_o(corr),
        .corr_valid_o(cval), .alarm_o(alarm), .pos_cnt_en_o(pce), .irq_o(irq));
    dtpi_fb_model fbm (.clk_i(clk), .volt_o(fbv), .curr_o(fbc), .valid_o(fbval));
    always #20 clk = ~clk;
    // One APB transfer; waits for ready, takes data at that edge.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        // Outputs settle here.
        @(negedge clk);
    endtask : apb
    task automatic cfg(input int md, ty, kp, ti, win, ofs, alm, mx);
        apb(1'b1, 8'h00, 32'(md) | (32'(ty) << 8));
        apb(1'b1, 8'h04, 32'(kp));
        apb(1'b1, 8'h08, 32'(ti));
        apb(1'b1, 8'h0C, 32'(win));
        apb(1'b1, 8'h10, {20'h0, 12'(ofs)});
        apb(1'b1, 8'h14, 32'(alm));
        apb(1'b1, 8'h18, 32'(mx));
    endtask : cfg
    // Sends a sample and notes whether a correction strobe followed.
    task automatic smp(input int v, input int c = 16'h0000);
        fbm.send(16'(v), 16'(c));
        got = 1'b0;
        repeat (6) begin
            @(negedge clk);
            if (cval === 1'b1) got = 1'b1;
        end
    endtask : smp
    task automatic t_reset;
        apb(1'b0, 8'h00, 32'h0);
        `CHK("ctrl", 32'h0000_0100, q)
        apb(1'b0, 8'h04, 32'h0);
        `CHK("pgain", 32'h0000_03E8, q)
        apb(1'b0, 8'h18, 32'h0);
        `CHK("maxcorr", 32'h0000_270F, q)
        `CHK("pce", 1'b1, pce)
        apb(1'b0, 8'h40, 32'h0);
        `CHK("unmapped", 1'b1, e)
    endtask : t_reset
    // Direction, offset and source select with unit gain.
    task automatic t_dir;
        cfg(1, 1, 1024, 0, 0, 0, 1000, 9999);
        smp(1000);
        `CHK("stb", 1'b1, got)
        `CHK("m1", 16'sh03E8, corr)
        `CHK("pce", 1'b0, pce)
        cfg(2, 1, 1024, 0, 0, 0, 1000, 9999);
        smp(1000);
        `CHK("m2", -16'sh03E8, corr)
        cfg(1, 1, 1024, 0, 0, 100, 1000, 9999);
        smp(3276 + 1000);
        `CHK("ofs", 16'sh03E8, corr)
        cfg(1, 2, 1024, 0, 0, 0, 1000, 9999);
        smp(0, 500);
        `CHK("curr", 16'sh01F4, corr)
    endtask : t_dir
    // Dead band edge, clamp and gain saturation.
    task automatic t_band;
        cfg(1, 1, 1024, 0, 10, 0, 1000, 1000);
        smp(327);
        `CHK("inwin", 16'sh0000, corr)
        smp(-328);
        `CHK("outwin", -16'sh0148, corr)
        smp(20000);
        `CHK("clamp", 16'sh03E8, corr)
        smp(-20000);
        `CHK("clampn", -16'sh03E8, corr)
        apb(1'b1, 8'h04, 32'h0000_FFFF);
        apb(1'b0, 8'h04, 32'h0);
        `CHK("gainsat", 32'h0000_270F, q)
    endtask : t_band
    // Alarm band, interrupt raise, clear and mask.
    task automatic t_alarm;
        cfg(1, 1, 1024, 0, 0, 0, 10, 9999);
        apb(1'b1, 8'h30, 32'h1);
        smp(327);
        `CHK("alm0", 1'b0, alarm)
        smp(328);
        `CHK("alm1", 1'b1, alarm)
        `CHK("irq", 1'b1, irq)
        apb(1'b1, 8'h2C, 32'h1);
        `CHK("irqclr", 1'b0, irq)
        apb(1'b1, 8'h30, 32'h0);
        smp(0);
        smp(-328);
        `CHK("almn", 1'b1, alarm)
        `CHK("masked", 1'b0, irq)
    endtask : t_alarm
    // Integrator grows, then is emptied by switching the loop off.
    task automatic t_integ;
        cfg(1, 1, 1024, 1, 0, 0, 1000, 9999);
        repeat (3) begin
            smp(100);
            repeat (25) @(posedge clk);
        end
        `CHK("integ", 1'b1, 1'(corr > 16'sh0064))
        for (int m = 0; m < 4; m += 3) begin
            cfg(m, 1, 1024, 0, 0, 0, 10, 9999);
            smp(2000);
            `CHK("offstb", 1'b0, got)
            `CHK("offcorr", 16'sh0000, corr)
            `CHK("offpce", 1'b1, pce)
        end
        cfg(1, 1, 1024, 0, 0, 0, 1000, 9999);
        smp(100);
        `CHK("ponly", 16'sh0064, corr)
    endtask : t_integ
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : complete_run
    // Main sequence after a 20-cycle reset.
    initial begin
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        t_reset;
        t_dir;
        t_band;
        t_alarm;
        t_integ;
        complete_run;
    end
    // Watchdog well beyond the expected run length.
    initial begin
        repeat (30000) @(posedge clk);
        err_count++;
        complete_run;
    end
endmodule : test_dancer_tension_pi_control
`default_nettype wire
